// File: hdl/tps_pkg.sv
// Constants, field layout and types of the ticket printer serial port.
// Assumes a 20 MHz system clock and word-wide AHB-Lite register access.
package tps_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BAUD_DEF = 9600;
   localparam logic [15:0] DIV16_RST = 16'(CLK_HZ / (BAUD_DEF * 16));
   localparam int unsigned PAPER_WAIT_MS = 100;
   localparam int unsigned PAPER_WAIT_CYC = (CLK_HZ / 1000) * PAPER_WAIT_MS;
   localparam int unsigned DW = 32;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_BAUD = 8'h04;
   localparam logic [7:0] A_TX = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_DATE = 8'h10;
   localparam logic [7:0] A_CNT = 8'h14;
   localparam logic [7:0] A_CMD = 8'h18;
   // Control register fields
   localparam int C_MODE = 0;
   localparam int C_KIND = 2;
   localparam int C_CTS = 5;
   localparam int C_PAR_EN = 6;
   localparam int C_PAR_ODD = 7;
   localparam int C_MFIRST = 8;
   localparam int C_STIME = 9;
   localparam int C_COMP = 10;
   localparam int C_SIGN = 11;
   localparam int C_POLL = 12;
   localparam int C_TGT_HH = 13;
   localparam int C_PASS = 14;
   localparam logic [14:0] CTRL_RST = 15'h00c0;
   // Communications modes and printer kinds
   localparam logic [1:0] M_PRN = 2'h0;
   localparam logic [1:0] M_HH = 2'h1;
   localparam logic [1:0] M_BOTH = 2'h2;
   localparam logic [2:0] K_SLIP_A = 3'h1;
   localparam logic [2:0] K_SLIP_B = 3'h3;
   // Ticket field kinds, bits 11:8 of a TX write
   localparam logic [3:0] F_HDR = 4'h1;
   localparam logic [3:0] F_TOT_S = 4'h2;
   localparam logic [3:0] F_TOT_F = 4'h3;
   localparam logic [3:0] F_GROSS = 4'h4;
   localparam logic [3:0] F_TEMP = 4'h5;
   localparam logic [3:0] F_VCF = 4'h6;
   localparam logic [3:0] F_SIGN = 4'h7;
   localparam logic [3:0] F_STIME = 4'h8;
   // Characters and limits
   localparam logic [7:0] XON = 8'h11;
   localparam logic [7:0] XOFF = 8'h13;
   localparam logic [7:0] LF = 8'h0a;
   localparam logic [7:0] PAPER_QUERY = 8'h05;
   localparam logic [7:0] PAPER_OUT_MASK = 8'h0c;
   localparam logic [1:0] HDR_LINES = 2'd2;
   localparam logic [4:0] HDR_CHARS = 5'd30;
   // Synchroniser lanes: printer rx, hand-held rx, printer cts
   localparam int P_PRX = 0;
   localparam int P_HRX = 1;
   localparam int P_CTS = 2;
   localparam logic [2:0] SYNC_RST = 3'h3;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_WAITP = 4'b0010,
      S_NUM = 4'b0100,
      S_OPEN = 4'b1000
   } tps_state_t;
endpackage : tps_pkg

// File: hdl/tps_rx_if.sv
// Link between the port core and its receiver.
// Assumes both ends run on the same clock.
interface tps_rx_if;
   logic tick16;
   logic line;
   logic par_en;
   logic par_odd;
   logic vld;
   logic [7:0] data;
   logic perr;
   modport core (output tick16, line, par_en, par_odd, input vld, data, perr);
   modport rx (input tick16, line, par_en, par_odd, output vld, data, perr);
endinterface : tps_rx_if

// File: hdl/tps_rx.sv
// Serial receiver, 16x oversampled, 8 data bits, optional parity.
// Assumes line is already synchronised to clk.
module tps_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Core side
   tps_rx_if.rx b
);
   import tps_pkg::*;
   typedef struct packed {
      logic busy;
      logic [3:0] sub;
      logic [3:0] n;
      logic [8:0] sh;
      logic vld;
      logic [7:0] data;
      logic perr;
   } tps_rx_state_t;
   tps_rx_state_t q, n;
   logic [3:0] last;

   // Sample mid-bit; a start bit gone high at mid-bit is a glitch
   always_comb begin
      n = q;
      n.vld = 1'b0;
      last = b.par_en ? 4'd10 : 4'd9;
      if (b.tick16) begin
         if (!q.busy) begin
            if (!b.line) begin
               n.busy = 1'b1;
               n.sub = 4'h0;
               n.n = 4'h0;
            end
         end else begin
            n.sub = q.sub + 4'h1;
            if (q.sub == 4'h7) begin
               n.n = q.n + 4'h1;
               if (q.n == 4'h0) begin
                  n.busy = !b.line;
               end else if (q.n == last) begin
                  n.busy = 1'b0;
                  n.vld = b.line;
                  n.data = b.par_en ? q.sh[7:0] : q.sh[8:1];
                  n.perr = b.par_en & ((^q.sh) != b.par_odd);
               end else begin
                  n.sh = {b.line, q.sh[8:1]};
               end
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign b.vld = q.vld;
   assign b.data = q.data;
   assign b.perr = q.perr;
endmodule : tps_rx

// File: hdl/tps_port.sv
// Ticket printer serial port: routing, flow control, paper check, ticket fields.
// Assumes an AHB-Lite master on clk; serial pins are asynchronous.
// How it works
// - Three modes; mode field writable only while no ticket runs.
// - Printer-only mode: hand-held line idles high.
// - Computer-only mode: printer line idles high, traffic on hand-held.
// - Combined mode: target bit sends traffic to one connector only.
// - Combined mode: pass bit wires hand-held receive straight to printer transmit.
// - Kind field selects printer type; kinds 1 and 3 are slip printers.
// - With CTS enabled, no byte starts while printer holds CTS high.
// - With CTS disabled, Xon/Xoff flow control is used.
// - Slip printers: query paper, start ticket only on good reply.
// - Reset gives 9600 baud, 8 bits, odd parity, CTS off.
// - Header characters beyond two lines of thirty are dropped.
// - Delivery counter advances per ticket and prints first.
// - Date order bit and start-time enable bit steer printed fields.
// - Ticket end flags an error unless both totals were sent.
// - Gross total only with compensation; status shows plain label.
// - Temperature printed only with compensation.
// - Signature line printed only when enabled.
// - Computer-only mode: poll bit picks polled or interrupt hand-held exchange.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
module tps_port #(
   parameter int unsigned PAPER_WAIT = tps_pkg::PAPER_WAIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [tps_pkg::DW-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [tps_pkg::DW-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [tps_pkg::DW-1:0] hrdata,
   // Printer connector
   output logic prn_txd,
   input wire logic prn_rxd,
   input wire logic prn_cts,
   // Hand-held connector
   output logic hh_txd,
   input wire logic hh_rxd,
   // Hand-held exchange style
   output logic hh_poll_style
);
   import tps_pkg::*;
   typedef struct packed {
      logic [14:0] ctrl;
      logic [15:0] div;
      logic [15:0] date;
      logic [15:0] cnt;
      logic a_wr;
      logic [7:0] a_addr;
      logic [31:0] rdata;
      logic rdy;
      logic [15:0] tcnt;
      logic tick;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] cln;
      tps_state_t st;
      logic [2:0] idx;
      logic [31:0] wcnt;
      logic paper_ok;
      logic paper_fail;
      logic tot_s;
      logic tot_f;
      logic tot_err;
      logic ovr;
      logic [1:0] hline;
      logic [4:0] hcol;
      logic [7:0] hold;
      logic hold_vld;
      logic xoff;
      logic [10:0] sh;
      logic [3:0] nb;
      logic [3:0] sub;
      logic busy;
      logic ptx;
      logic htx;
      logic poll;
   } tps_main_t;
   tps_main_t q, n;
   tps_rx_if rxb ();
   logic [1:0] mode;
   logic slip, to_hh, pass, cts_busy, pause, line, keep;
   logic cmd_start, cmd_end, txw;
   logic [3:0] fk;
   logic [7:0] ch, asc;
   logic [15:0] sel;
   logic [3:0] nib;

   // Routing decode shared by receiver and transmitter
   assign mode = q.ctrl[C_MODE+:2];
   assign slip = (q.ctrl[C_KIND+:3] == K_SLIP_A) || (q.ctrl[C_KIND+:3] == K_SLIP_B);
   assign to_hh = (mode == M_HH) || ((mode == M_BOTH) && q.ctrl[C_TGT_HH]);
   assign pass = (mode == M_BOTH) && q.ctrl[C_PASS];
   assign cts_busy = q.cln[P_CTS];
   assign rxb.tick16 = q.tick;
   assign rxb.line = to_hh ? q.cln[P_HRX] : q.cln[P_PRX];
   assign rxb.par_en = q.ctrl[C_PAR_EN];
   assign rxb.par_odd = q.ctrl[C_PAR_ODD];

   tps_rx u_rx (
      .clk(clk),
      .sys_rst(sys_rst),
      .b(rxb.rx)
   );

   // Next state of the whole port
   always_comb begin
      n = q;
      n.tick = 1'b0;
      n.rdy = 1'b1;
      n.a_wr = 1'b0;
      keep = 1'b1;
      // Baud divider gives a 16x oversampling enable
      if (q.tcnt >= q.div - 16'h1) begin
         n.tcnt = 16'h0;
         n.tick = 1'b1;
      end else begin
         n.tcnt = q.tcnt + 16'h1;
      end
      // Three-stage pin sync; a level counts once stages two and three agree
      n.s1 = {prn_cts, hh_rxd, prn_rxd};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.cln = (q.s2 & q.s3) | (q.cln & (q.s2 | q.s3));
      // Address phase: read data is captured now, so no wait states
      if (hsel && htrans[1] && hready) begin
         n.a_wr = hwrite;
         n.a_addr = haddr[7:0];
         case (haddr[7:0])
            A_CTRL: n.rdata = {17'h0, q.ctrl};
            A_BAUD: n.rdata = {16'h0, q.div};
            A_STAT: n.rdata = {19'h0, q.st, !q.ctrl[C_COMP], q.ovr, q.tot_err, q.paper_fail,
                               q.paper_ok, q.xoff, cts_busy, q.busy, q.hold_vld};
            A_DATE: n.rdata = {16'h0, q.date};
            A_CNT: n.rdata = {16'h0, q.cnt};
            default: n.rdata = 32'h0;
         endcase
      end
      // Data phase writes
      cmd_start = q.a_wr && (q.a_addr == A_CMD) && hwdata[0];
      cmd_end = q.a_wr && (q.a_addr == A_CMD) && hwdata[1];
      txw = q.a_wr && (q.a_addr == A_TX);
      fk = hwdata[11:8];
      ch = hwdata[7:0];
      if (q.a_wr && (q.a_addr == A_CTRL)) begin
         n.ctrl = hwdata[14:0];
         if (q.st != S_IDLE) begin
            n.ctrl[C_MODE+:2] = q.ctrl[C_MODE+:2];
         end
      end
      if (q.a_wr && (q.a_addr == A_BAUD)) begin
         n.div = hwdata[15:0];
      end
      if (q.a_wr && (q.a_addr == A_DATE)) begin
         n.date = hwdata[15:0];
      end
      // Software flow control only when CTS is off; a byte with bad parity could fake a pause
      if (rxb.vld && !rxb.perr && !to_hh && !q.ctrl[C_CTS]) begin
         if (rxb.data == XOFF) begin
            n.xoff = 1'b1;
         end else if (rxb.data == XON) begin
            n.xoff = 1'b0;
         end
      end
      // Pausing only between bytes keeps frames whole
      pause = !to_hh && (q.ctrl[C_CTS] ? cts_busy : q.xoff);
      if (q.busy) begin
         if (q.tick) begin
            n.sub = q.sub + 4'h1;
            if (q.sub == 4'hf) begin
               n.sh = {1'b1, q.sh[10:1]};
               n.nb = q.nb - 4'h1;
               n.busy = (q.nb != 4'h1);
            end
         end
      end else if (q.hold_vld && !pause) begin
         n.busy = 1'b1;
         n.sub = 4'h0;
         n.hold_vld = 1'b0;
         n.nb = q.ctrl[C_PAR_EN] ? 4'd11 : 4'd10;
         n.sh = {1'b1, q.ctrl[C_PAR_EN] ? ((^q.hold) ^ q.ctrl[C_PAR_ODD]) : 1'b1, q.hold, 1'b0};
      end
      line = q.busy ? q.sh[0] : 1'b1;
      n.ptx = pass ? q.cln[P_HRX] : (to_hh ? 1'b1 : line);
      n.htx = to_hh ? line : 1'b1;
      n.poll = q.ctrl[C_POLL] && (mode == M_HH);
      // Counter digits then date digits, in the chosen order
      sel = (q.idx[2] == 1'b0) ? q.cnt : (q.ctrl[C_MFIRST] ? q.date : {q.date[7:0], q.date[15:8]});
      nib = sel[{~q.idx[1:0], 2'b11} -: 4];
      asc = (nib < 4'ha) ? 8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};
      // Field filter for ticket text written by software
      case (fk)
         F_GROSS, F_TEMP, F_VCF: keep = q.ctrl[C_COMP];
         F_SIGN: keep = q.ctrl[C_SIGN];
         F_STIME: keep = q.ctrl[C_STIME];
         F_HDR: keep = (q.hline < HDR_LINES) && ((ch == LF) || (q.hcol < HDR_CHARS));
         default: keep = 1'b1;
      endcase
      if (txw && (q.st != S_OPEN || q.hold_vld)) begin
         n.ovr = 1'b1;
      end
      // Ticket sequencer
      case (q.st)
         S_IDLE: begin
            if (cmd_start) begin
               n.cnt = q.cnt + 16'h1;
               {n.paper_ok, n.paper_fail, n.tot_s, n.tot_f, n.tot_err, n.ovr} = 6'h0;
               n.idx = 3'h0;
               n.hline = 2'h0;
               n.hcol = 5'h0;
               if (slip) begin
                  n.hold = PAPER_QUERY;
                  n.hold_vld = 1'b1;
                  n.wcnt = 32'h0;
                  n.st = S_WAITP;
               end else begin
                  n.st = S_NUM;
               end
            end
         end
         S_WAITP: begin
            n.wcnt = q.wcnt + 32'h1;
            if (rxb.vld && ((rxb.data & PAPER_OUT_MASK) == 8'h0)) begin
               n.paper_ok = 1'b1;
               n.st = S_NUM;
            end else if (rxb.vld || (q.wcnt == PAPER_WAIT - 32'h1)) begin
               n.paper_fail = 1'b1;
               n.st = S_IDLE;
            end
         end
         S_NUM: begin
            if (!q.hold_vld) begin
               n.hold = asc;
               n.hold_vld = 1'b1;
               n.idx = q.idx + 3'h1;
               if (q.idx == 3'h7) begin
                  n.st = S_OPEN;
               end
            end
         end
         S_OPEN: begin
            if (txw && !q.hold_vld) begin
               n.tot_s = q.tot_s | (fk == F_TOT_S);
               n.tot_f = q.tot_f | (fk == F_TOT_F);
               if (fk == F_HDR) begin
                  if (ch == LF) begin
                     n.hcol = 5'h0;
                     n.hline = (q.hline < HDR_LINES) ? q.hline + 2'h1 : q.hline;
                  end else if (keep) begin
                     n.hcol = q.hcol + 5'h1;
                  end
               end
               if (keep) begin
                  n.hold = ch;
                  n.hold_vld = 1'b1;
               end
            end
            if (cmd_end) begin
               n.tot_err = !(n.tot_s && n.tot_f);
               n.st = S_IDLE;
            end
         end
         default: n.st = S_IDLE;
      endcase
   end

   // State register; defaults give 9600 baud, odd parity, CTS off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.div <= DIV16_RST;
         q.st <= S_IDLE;
         q.ptx <= 1'b1;
         q.htx <= 1'b1;
         q.s1 <= SYNC_RST;
         q.s2 <= SYNC_RST;
         q.s3 <= SYNC_RST;
         q.cln <= SYNC_RST;
      end else begin
         q <= n;
      end
   end

   assign hreadyout = q.rdy;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign prn_txd = q.ptx;
   assign hh_txd = q.htx;
   assign hh_poll_style = q.poll;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_slip_start;
      (q.st == S_IDLE) && cmd_start && slip;
   endsequence
   sequence s_query_loaded;
      (q.st == S_WAITP) && q.hold_vld && (q.hold == PAPER_QUERY);
   endsequence

   AST_PAPER_QUERY: assert property (s_slip_start |=> s_query_loaded)
      else $error("slip ticket did not query paper");
   AST_PAPER_GATE: assert property ((q.st == S_NUM) && $past(q.st == S_WAITP) |-> q.paper_ok)
      else $error("ticket started without paper");
   AST_CTS_HOLD: assert property (!q.busy && !to_hh && q.ctrl[C_CTS] && cts_busy |=> !q.busy)
      else $error("byte started while printer busy");
   AST_XOFF: assert property (rxb.vld && !rxb.perr && (rxb.data == XOFF) && !to_hh && !q.ctrl[C_CTS] |=> q.xoff)
      else $error("xoff not taken");
   AST_MODE_LOCK: assert property ((q.st != S_IDLE) |=> mode == $past(mode))
      else $error("mode changed during a ticket");
   AST_PRN_QUIET: assert property ((mode == M_HH) |=> prn_txd)
      else $error("printer driven in computer-only mode");
   AST_HH_QUIET: assert property ((mode == M_PRN) |=> hh_txd)
      else $error("hand-held driven in printer-only mode");
   AST_ONE_WAY: assert property ((mode == M_BOTH) && !pass |=> prn_txd || hh_txd)
      else $error("both connectors active");
   AST_PASS: assert property (pass |=> prn_txd == $past(q.cln[P_HRX]))
      else $error("pass-through broken");
   AST_COUNT: assert property ((q.st == S_IDLE) && cmd_start |=> q.cnt == $past(q.cnt) + 16'h1)
      else $error("delivery counter did not advance");
   AST_HDR_LIMIT: assert property (q.hcol <= HDR_CHARS && q.hline <= HDR_LINES)
      else $error("header limit exceeded");
   AST_TEMP_DROP: assert property (txw && (q.st == S_OPEN) && !q.hold_vld && (fk == F_TEMP)
                                   && !q.ctrl[C_COMP] |=> !q.hold_vld)
      else $error("temperature printed without compensation");
   AST_DEFAULTS: assert property ($past(sys_rst) |-> (q.ctrl == CTRL_RST) && (q.div == DIV16_RST))
      else $error("wrong defaults after reset");
endmodule : tps_port

// File: test/tps_partner.sv
// Printer and hand-held model: decodes both transmit lines and answers paper queries.
// Assumes 8 data bits, odd parity and one stop bit, BIT clocks to a bit.
module tps_partner #(
   parameter int BIT = 32
) (
   // Clock
   input wire logic clk,
   // From the port
   input wire logic prn_txd,
   input wire logic hh_txd,
   // To the port
   output logic prn_rxd,
   output logic hh_rxd,
   output logic prn_cts,
   // Bench controls
   input wire logic [7:0] paper_reply,
   input wire logic cts_hold
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] prn_q[$];
   logic [7:0] hh_q[$];
   int perr = 0;
   // Busy level comes straight from the bench
   assign prn_cts = cts_hold;
   // Both lines idle at mark
   initial begin
      prn_rxd = 1'b1;
      hh_rxd = 1'b1;
   end
   // Sample mid-bit; half a bit of margin covers a short first bit
   task automatic grab(input bit hh, output logic [7:0] d);
      logic [9:0] f;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT) @(posedge clk);
         f[i] = hh ? hh_txd : prn_txd;
      end
      d = f[7:0];
      if (^f[8:0] !== 1'b1 || f[9] !== 1'b1) perr++;  // odd parity and stop
   endtask : grab
   // One odd-parity frame toward the port
   task automatic send(input bit hh, input logic [7:0] d);
      logic [10:0] f;
      f = {1'b1, ~^d, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (hh) hh_rxd <= f[i];
         else prn_rxd <= f[i];
         repeat (BIT) @(posedge clk);
      end
   endtask : send
   // Printer: log frames, answer a paper query one bit later
   always begin : prn_mon
      logic [7:0] d;
      @(negedge prn_txd);
      grab(1'b0, d);
      prn_q.push_back(d);
      // Reply runs on its own so the first digit after the reply is not missed
      if (d === tps_pkg::PAPER_QUERY) begin
         fork
            begin
               repeat (BIT) @(posedge clk);
               send(1'b0, paper_reply);
            end
         join_none
      end
   end
   // Hand-held: log frames
   always begin : hh_mon
      logic [7:0] d;
      @(negedge hh_txd);
      grab(1'b1, d);
      hh_q.push_back(d);
   end
endmodule : tps_partner

// File: test/ticket_printer_serial_port_bench.sv
// Self-checking bench of the ticket printer serial port.
// Assumes zero-wait bus answers and a partner model on both connectors.
module ticket_printer_serial_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tps_pkg::*;
   localparam int DIV = 2;
   localparam int BIT = 16 * DIV;
   // Bus and pin drive
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] reply = 8'h00;
   logic cts = 1'b0;
   wire logic hreadyout, hresp, prn_txd, prn_rxd, prn_cts, hh_txd, hh_rxd, hh_poll_style;
   wire logic [31:0] hrdata;
   // Bench state
   int errors = 0;
   int check_count = 0;
   int cnt = 0;
   logic [31:0] seed = 32'h29;
   logic [31:0] rd;
   logic [7:0] c;
   logic [3:0] fk[5] = '{F_GROSS, F_TEMP, F_VCF, F_SIGN, F_STIME};
   int cb[5] = '{C_COMP, C_COMP, C_COMP, C_SIGN, C_STIME};

   // Short paper wait keeps the slip cases quick
   tps_port #(.PAPER_WAIT(2000)) dut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .prn_txd(prn_txd), .prn_rxd(prn_rxd), .prn_cts(prn_cts), .hh_txd(hh_txd),
      .hh_rxd(hh_rxd), .hh_poll_style(hh_poll_style));
   tps_partner #(.BIT(BIT)) prt (
      .clk(clk), .prn_txd(prn_txd), .hh_txd(hh_txd), .prn_rxd(prn_rxd), .hh_rxd(hh_rxd),
      .prn_cts(prn_cts), .paper_reply(reply), .cts_hold(cts));

   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] qat(input bit hh, input int i);
      return hh ? prt.hh_q[i] : prt.prn_q[i];
   endfunction : qat
   function automatic int qsz(input bit hh);
      return hh ? prt.hh_q.size() : prt.prn_q.size();
   endfunction : qsz

   task automatic end_sim();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic lim(input int k, input int n);
      if (k >= n) begin
         errors++;
         end_sim();
      end
   endtask : lim
   task automatic rdy();
      int k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 100);
      lim(k, 100);
   endtask : rdy
   // One single word transfer; read data taken at the data phase edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask : bus
   task automatic wait_q(input bit hh, input int n);
      int k = 0;
      while (qsz(hh) < n && k < 20000) begin
         @(posedge clk);
         k++;
      end
      lim(k, 20000);
   endtask : wait_q
   // Write a character only once the hold register is free
   task automatic tx(input logic [3:0] f, input logic [7:0] ch);
      int k = 0;
      do begin
         bus(A_STAT, 1'b0, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 2000);
      lim(k, 2000);
      bus(A_TX, 1'b1, {20'h0, f, ch});
   endtask : tx
   // Start a ticket and check the counter and date digits
   task automatic start(input bit hh, input logic mf, input bit sl);
      logic [31:0] v;
      prt.prn_q.delete();
      prt.hh_q.delete();
      cnt++;
      bus(A_CMD, 1'b1, 32'h1);
      v = {cnt[15:0], mf ? 16'h1225 : 16'h2512};
      wait_q(hh, 8 + sl);
      if (sl) chk(32'(prt.prn_q[0]), 32'(PAPER_QUERY));
      for (int i = 0; i < 8; i++) chk(32'(qat(hh, i + sl)), 32'h30 + 32'(v[31 - 4 * i -: 4]));
   endtask : start
   // Ticket fields, totals and end; expected stream built from the options
   task automatic body(input bit hh, input logic [31:0] ctl, input int hdr, input logic fin);
      logic [7:0] e[$];
      prt.prn_q.delete();
      prt.hh_q.delete();
      for (int i = 0; i < hdr; i++) begin
         tx(F_HDR, 8'h61);
         if (i < 30) e.push_back(8'h61);
      end
      for (int i = 0; i < 5; i++) begin
         tx(fk[i], 8'h41 + 8'(i));
         if (ctl[cb[i]]) e.push_back(8'h41 + 8'(i));
      end
      for (int i = 0; i < 2; i++) begin
         // Kept above the control codes, so the printer model never sees a stray paper query
         c = 8'(rnd()) | 8'h20;
         tx(4'h0, c);
         e.push_back(c);
      end
      tx(F_TOT_S, 8'h31);
      e.push_back(8'h31);
      if (fin) begin
         tx(F_TOT_F, 8'h32);
         e.push_back(8'h32);
      end
      wait_q(hh, e.size());
      foreach (e[i]) chk(32'(qat(hh, i)), 32'(e[i]));
      bus(A_CMD, 1'b1, 32'h2);
      bus(A_STAT, 1'b0, 32'h0);
      chk(32'({rd[8], rd[6]}), 32'({~ctl[C_COMP], ~fin}));
      chk(32'(qsz(~hh)), 32'h0);
   endtask : body

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      bus(A_CTRL, 1'b0, 32'h0);
      chk(rd, 32'(CTRL_RST));
      bus(A_BAUD, 1'b0, 32'h0);
      chk(rd, 32'(DIV16_RST));
      bus(8'h40, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(A_CNT, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(32'({prn_txd, hh_txd, hresp}), 32'h6);
      bus(A_BAUD, 1'b1, 32'(DIV));
      bus(A_DATE, 1'b1, 32'h1225);
      // Generic printer, day first, over-long header
      start(1'b0, 1'b0, 1'b0);
      body(1'b0, 32'h00c0, 31, 1'b1);
      // Month first with every option, finish total missing
      bus(A_CTRL, 1'b1, 32'h0fc0);
      start(1'b0, 1'b1, 1'b0);
      body(1'b0, 32'h0fc0, 0, 1'b0);
      // Slip printer with paper present
      bus(A_CTRL, 1'b1, 32'h00c4);
      start(1'b0, 1'b0, 1'b1);
      body(1'b0, 32'h00c4, 0, 1'b1);
      // Other slip printer reporting paper out: no digits follow
      bus(A_CTRL, 1'b1, 32'h00cc);
      reply <= 8'h0c;
      prt.prn_q.delete();
      cnt++;
      bus(A_CMD, 1'b1, 32'h1);
      wait_q(1'b0, 1);
      repeat (BIT * 16) @(posedge clk);
      bus(A_STAT, 1'b0, 32'h0);
      chk(32'({rd[12:9], rd[5]}), 32'h3);
      chk(32'(prt.prn_q.size()), 32'h1);
      // Hardware handshake holds the digits back
      cts <= 1'b1;
      bus(A_CTRL, 1'b1, 32'h00e8);
      prt.prn_q.delete();
      cnt++;
      bus(A_CMD, 1'b1, 32'h1);
      repeat (BIT * 24) @(posedge clk);
      bus(A_STAT, 1'b0, 32'h0);
      chk(32'({rd[2], 8'(prt.prn_q.size())}), 32'h100);
      bus(A_CTRL, 1'b1, 32'h00e9);
      bus(A_CTRL, 1'b0, 32'h0);
      chk(rd, 32'h00e8);
      cts <= 1'b0;
      wait_q(1'b0, 8);
      bus(A_CMD, 1'b1, 32'h2);
      // Software flow control pauses and resumes
      bus(A_CTRL, 1'b1, 32'h00d0);
      start(1'b0, 1'b0, 1'b0);
      prt.send(1'b0, XOFF);
      repeat (BIT) @(posedge clk);
      bus(A_STAT, 1'b0, 32'h0);
      chk(32'(rd[3]), 32'h1);
      tx(4'h0, 8'h5a);
      repeat (BIT * 24) @(posedge clk);
      chk(32'(prt.prn_q.size()), 32'h8);
      prt.send(1'b0, XON);
      wait_q(1'b0, 9);
      chk(32'(prt.prn_q[8]), 32'h5a);
      bus(A_CMD, 1'b1, 32'h2);
      // Computer-only mode, polled exchange
      bus(A_CTRL, 1'b1, 32'h10c1);
      start(1'b1, 1'b0, 1'b0);
      chk(32'(hh_poll_style), 32'h1);
      body(1'b1, 32'h10c1, 0, 1'b1);
      // Combined mode toward each connector in turn
      bus(A_CTRL, 1'b1, 32'h00c2);
      start(1'b0, 1'b0, 1'b0);
      chk(32'(hh_poll_style), 32'h0);
      body(1'b0, 32'h00c2, 0, 1'b1);
      bus(A_CTRL, 1'b1, 32'h20c2);
      start(1'b1, 1'b0, 1'b0);
      body(1'b1, 32'h20c2, 0, 1'b1);
      // Hand-held wired through to the printer
      bus(A_CTRL, 1'b1, 32'h60c2);
      prt.prn_q.delete();
      c = 8'(rnd());
      prt.send(1'b1, c);
      wait_q(1'b0, 1);
      chk(32'(prt.prn_q[0]), 32'(c));
      chk(32'(prt.perr), 32'h0);
      end_sim();
   end

   // Hang guard
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule : ticket_printer_serial_port_bench
